// File: rtl/apedp_top.sv
// active power and energy datapath: multiply, lowpass, offset, gain, no-load, divide, accumulate
// assumes samples synchronous to clk, valid every cycle; register port answers one cycle later
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps

// Operation
// - multiply current and voltage, then lowpass
// - scale power by one plus gain/4096
// - gain 0x7FF +50 percent, 0x800 -50
// - add signed 16-bit power offset
// - offset LSB is 1/256 sample LSB
// - default: flag positive-to-negative sign change
// - direction bit set: flag negative-to-positive
// - sign flag and enable raise interrupt
// - below threshold: no accumulation, set flag
// - two-bit field selects no-load threshold
// - no-load flag and enable raise interrupt
// - 49-bit accumulator, upper 24 bits readable
// - accumulate once every five clocks
// - clear bits signed; both set positive-only
// - positive-only or magnitude accumulation modes
// - divide by 8-bit divisor, zero means one
// - read-clear returns energy, clears upper bits
// - waveform output at four selectable rates
// - energy wraps on overflow and underflow
// - half-full and overflow events raise interrupt
// - positive-only ignores all negative power
module apedp_top #(
  parameter int WAVE_BASE_CYCLES = apedp_pkg::WAVE_CYCLES
) (
  input logic clk,
  input logic nrst,
  input apedp_pkg::apedp_bus_type bus,
  input apedp_pkg::apedp_sample_type samples,
  output logic [23:0] reg_rdata,
  output logic irq_pending,
  output apedp_pkg::apedp_wave_type wave
);
  import apedp_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic [23:0] nl_threshold(input logic [1:0] sel);
    logic [23:0] thr;
    thr = 24'h000000;
    case (sel)
      2'h1: thr = NL_THR_1;
      2'h2: thr = NL_THR_2;
      2'h3: thr = NL_THR_3;
      default: thr = 24'h000000;
    endcase
    return thr;
  endfunction

  apedp_state_type s_reg;
  apedp_state_type s_next;

  logic step;
  logic signed [47:0] prod;
  logic signed [23:0] p_inst;
  logic signed [31:0] lpf_err;
  logic signed [31:0] corr;
  logic signed [43:0] gain_prod;
  logic signed [31:0] gained;
  logic signed [23:0] pwr;
  logic [23:0] mag;
  logic [23:0] thr;
  logic no_load;
  logic pos_only;
  logic abs_mode;
  logic negate;
  logic [23:0] mag_sel;
  logic [7:0] div;
  logic [23:0] quot;
  logic signed [48:0] inc;
  logic signed [48:0] acc_base;
  logic signed [48:0] acc_sum;
  logic rd_clear;
  logic [7:0] stat_set;
  logic [7:0] stat_clr;
  logic [7:0] keep_mask;
  logic [13:0] wave_period;

  // ==========================================================
  // power path
  // five-clock step
  assign step = (s_reg.step_cnt == STEP_LAST);
  assign prod = samples.current * samples.voltage;
  assign p_inst = prod[46:23];
  assign lpf_err = $signed({p_inst, 8'h00}) - s_reg.lpf;
  assign corr = s_reg.lpf + {{16{s_reg.offset[15]}}, s_reg.offset};
  // gain as signed fraction of 4096
  // full code range gives plus or minus half
  assign gain_prod = corr * $signed(s_reg.gain);
  assign gained = corr + gain_prod[43:12];
  assign pwr = gained[31:8];
  assign mag = pwr[23] ? 24'(-pwr) : pwr;           // 0x800000 reads as its true magnitude

  // ==========================================================
  // no-load and accumulation mode
  // threshold select
  assign thr = nl_threshold(s_reg.nl_mode[1:0]);
  // below threshold counts as no load
  assign no_load = (thr != 24'h000000) && (mag < thr);
  // both bits set falls to positive-only
  assign pos_only = s_reg.acc_mode[ACC_POS_ONLY_BIT];
  assign abs_mode = s_reg.acc_mode[ACC_ABS_BIT] & ~pos_only;
  assign negate = ~pos_only & ~abs_mode & pwr[23];

  always_comb begin
    if (no_load) begin
      mag_sel = 24'h000000;
    end else if (pos_only && pwr[23]) begin
      mag_sel = 24'h000000;
    end else begin
      mag_sel = mag;
    end
  end

  // zero divisor acts as one; a full divider costs area but keeps one step per five clocks
  assign div = (s_reg.divider == 8'h00) ? 8'h01 : s_reg.divider;
  assign quot = mag_sel / {16'h0000, div};
  assign inc = negate ? -$signed({25'h0000000, quot}) : $signed({25'h0000000, quot});

  // read-clear drops upper bits, lower bits kept
  assign rd_clear = bus.rd && (bus.addr == ADDR_ENERGY_RC);
  assign acc_base = rd_clear ? {24'h000000, s_reg.acc[24:0]} : s_reg.acc;
  assign acc_sum = acc_base + inc;
  assign wave_period = 14'(WAVE_BASE_CYCLES) << s_reg.wave_src[WAVE_RATE_LSB +: 2];

  // ==========================================================
  // event flags
  always_comb begin
    stat_set = 8'h00;
    stat_clr = 8'h00;
    if (step) begin
      if (s_reg.acc_mode[ACC_SIGN_DIR_BIT]) begin
        stat_set[STAT_SIGN_BIT] = s_reg.prev_neg & ~pwr[23];
      end else begin
        stat_set[STAT_SIGN_BIT] = ~s_reg.prev_neg & pwr[23];
      end
      stat_set[STAT_NOLOAD_BIT] = no_load;
      stat_set[STAT_HALF_BIT] = (~acc_sum[48] & acc_sum[47] & ~acc_base[47])
                              | (acc_sum[48] & ~acc_sum[47] & acc_base[47]);
      stat_set[STAT_OVF_BIT] = (~inc[48] & ~acc_base[48] & acc_sum[48])
                             | (inc[48] & acc_base[48] & ~acc_sum[48]);
    end
    if (bus.wr && (bus.addr == ADDR_IRQ_STAT_LOW)) begin
      stat_clr = bus.wdata[7:0];                     // write one to clear
    end
  end
  assign keep_mask = s_reg.stat_low & ~stat_clr;

  // ==========================================================
  // next state
  always_comb begin
    s_next = s_reg;
    s_next.step_cnt = step ? 3'h0 : s_reg.step_cnt + 3'h1;
    s_next.wave_valid = 1'b0;
    s_next.stat_low = (keep_mask | stat_set) & STAT_USED_MASK;
    // any enabled flag holds the interrupt
    s_next.irq = |(s_reg.stat_low & s_reg.en_low);
    s_next.acc = acc_base;
    if (step) begin
      s_next.lpf = s_reg.lpf + (lpf_err >>> LPF_SHIFT);
      s_next.power = pwr;
      s_next.prev_neg = pwr[23];
      s_next.acc = acc_sum;
    end
    if (s_reg.wave_cnt >= wave_period - 14'h0001) begin
      s_next.wave_cnt = 14'h0000;
      if (s_reg.en_high[EN_HIGH_WAVE_BIT] && (s_reg.wave_src[2:0] == WAVE_SRC_ACTIVE)) begin
        s_next.wave_valid = 1'b1;
        s_next.wave_data = s_reg.power;
      end
    end else begin
      s_next.wave_cnt = s_reg.wave_cnt + 14'h0001;
    end
    // register writes
    if (bus.wr) begin
      if (bus.addr == ADDR_WAVE_SRC) begin
        s_next.wave_src = bus.wdata[7:0];
      end else if (bus.addr == ADDR_NL_MODE) begin
        s_next.nl_mode = bus.wdata[7:0];
      end else if (bus.addr == ADDR_ACC_MODE) begin
        s_next.acc_mode = bus.wdata[7:0];
      end else if (bus.addr == ADDR_GAIN) begin
        s_next.gain = bus.wdata[11:0];
      end else if (bus.addr == ADDR_OFFSET) begin
        s_next.offset = bus.wdata[15:0];
      end else if (bus.addr == ADDR_DIVIDER) begin
        s_next.divider = bus.wdata[7:0];
      end else if (bus.addr == ADDR_IRQ_EN_LOW) begin
        s_next.en_low = bus.wdata[7:0];
      end else if (bus.addr == ADDR_IRQ_EN_HIGH) begin
        s_next.en_high = bus.wdata[7:0];
      end
    end
    // register reads, unmapped reads give zero
    s_next.rdata = 24'h000000;
    if (bus.rd) begin
      if (bus.addr == ADDR_WAVE_SRC) begin
        s_next.rdata = {16'h0000, s_reg.wave_src};
      end else if (bus.addr == ADDR_NL_MODE) begin
        s_next.rdata = {16'h0000, s_reg.nl_mode};
      end else if (bus.addr == ADDR_ACC_MODE) begin
        s_next.rdata = {16'h0000, s_reg.acc_mode};
      end else if (bus.addr == ADDR_GAIN) begin
        s_next.rdata = {12'h000, s_reg.gain};
      end else if (bus.addr == ADDR_OFFSET) begin
        s_next.rdata = {8'h00, s_reg.offset};
      end else if (bus.addr == ADDR_DIVIDER) begin
        s_next.rdata = {16'h0000, s_reg.divider};
      end else if ((bus.addr == ADDR_ENERGY) || rd_clear) begin
        s_next.rdata = s_reg.acc[48:25];
      end else if (bus.addr == ADDR_IRQ_EN_LOW) begin
        s_next.rdata = {16'h0000, s_reg.en_low};
      end else if (bus.addr == ADDR_IRQ_EN_HIGH) begin
        s_next.rdata = {16'h0000, s_reg.en_high};
      end else if (bus.addr == ADDR_IRQ_STAT_LOW) begin
        s_next.rdata = {16'h0000, s_reg.stat_low};
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_reg <= '0;
      s_reg.gain <= RST_GAIN;
      s_reg.offset <= RST_OFFSET;
      s_reg.acc_mode <= RST_BYTE;                    // positive-only off after reset
      s_reg.nl_mode <= RST_BYTE;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign reg_rdata = s_reg.rdata;
  assign irq_pending = s_reg.irq;
  assign wave.data = s_reg.wave_data;
  assign wave.valid = s_reg.wave_valid;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  step_period_a: assert property (step |=> !step [*4] ##1 step)
    else $error("accumulation step not every five clocks");
  rc_clear_a: assert property ((rd_clear && !step) |=> s_reg.acc[48:25] == 24'h000000)
    else $error("read-clear left upper energy bits");
  rc_data_a: assert property (rd_clear |=> reg_rdata == $past(s_reg.acc[48:25]))
    else $error("read-clear returned wrong energy");
  noload_flag_a: assert property ((step && no_load) |=> s_reg.stat_low[STAT_NOLOAD_BIT])
    else $error("no-load flag not set");
  noload_hold_a: assert property ((step && no_load && !rd_clear) |=> s_reg.acc == $past(s_reg.acc))
    else $error("energy accumulated under no load");
  irq_hold_a: assert property (((s_reg.stat_low & s_reg.en_low) != 8'h00) |=> irq_pending)
    else $error("enabled flag without interrupt");
  sign_fall_a: assert property ((step && !s_reg.acc_mode[ACC_SIGN_DIR_BIT] && !s_reg.prev_neg && pwr[23])
    |=> s_reg.stat_low[STAT_SIGN_BIT])
    else $error("positive to negative change missed");
  sign_rise_a: assert property ((step && s_reg.acc_mode[ACC_SIGN_DIR_BIT] && s_reg.prev_neg && !pwr[23])
    |=> s_reg.stat_low[STAT_SIGN_BIT])
    else $error("negative to positive change missed");
  pos_only_a: assert property ((step && pos_only && pwr[23] && !rd_clear) |=> s_reg.acc == $past(s_reg.acc))
    else $error("negative power accumulated in positive-only mode");
  flag_sticky_a: assert property (1'b1 |=> ((s_reg.stat_low & $past(keep_mask)) == $past(keep_mask)))
    else $error("status flag dropped without clear");

  noload_c: cover property (step && no_load);
  wrap_c: cover property (s_reg.stat_low[STAT_OVF_BIT]);
  wave_c: cover property (wave.valid);
  rc_c: cover property (rd_clear ##1 step);

endmodule

// File: rtl/apedp_pkg.sv
// package for the active power and energy datapath: offsets, fields, resets, timing, carriers
// assumes a 50 MHz metering clock and an 8-bit register address space
package apedp_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_HZ = 50_000_000;
  localparam int STEP_CYCLES = 5;                    // master clocks per accumulation step
  localparam logic [2:0] STEP_LAST = 3'(STEP_CYCLES - 1);
  localparam int WAVE_RATE_HZ = 25_600;              // fastest waveform sample rate
  localparam int WAVE_CYCLES = CLK_HZ / WAVE_RATE_HZ; // shortest period rounds down
  localparam int LPF_SHIFT = 8;                      // lowpass pole, 2^-8 per step

  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_WAVE_SRC = 8'h0D;
  localparam logic [7:0] ADDR_NL_MODE = 8'h0E;
  localparam logic [7:0] ADDR_ACC_MODE = 8'h0F;
  localparam logic [7:0] ADDR_GAIN = 8'h10;
  localparam logic [7:0] ADDR_OFFSET = 8'h11;
  localparam logic [7:0] ADDR_DIVIDER = 8'h12;
  localparam logic [7:0] ADDR_ENERGY = 8'h13;
  localparam logic [7:0] ADDR_ENERGY_RC = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EN_LOW = 8'hD9;
  localparam logic [7:0] ADDR_IRQ_EN_HIGH = 8'hDB;
  localparam logic [7:0] ADDR_IRQ_STAT_LOW = 8'hDC;

  // ==========================================================
  // field positions and codes
  localparam int ACC_SIGN_DIR_BIT = 0;
  localparam int ACC_POS_ONLY_BIT = 1;
  localparam int ACC_ABS_BIT = 2;
  localparam int STAT_SIGN_BIT = 0;
  localparam int STAT_NOLOAD_BIT = 1;
  localparam int STAT_HALF_BIT = 2;
  localparam int STAT_OVF_BIT = 3;
  localparam int EN_HIGH_WAVE_BIT = 0;
  localparam int WAVE_RATE_LSB = 3;
  localparam logic [2:0] WAVE_SRC_ACTIVE = 3'h0;
  localparam logic [7:0] STAT_USED_MASK = 8'h0F;

  // no-load thresholds as magnitude of the 24-bit power value (fraction of 2^23)
  localparam logic [23:0] NL_THR_1 = 24'h0004EA;     // 0.015 %
  localparam logic [23:0] NL_THR_2 = 24'h000275;     // 0.0075 %
  localparam logic [23:0] NL_THR_3 = 24'h000136;     // 0.0037 %

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [11:0] RST_GAIN = 12'h000;
  localparam logic [15:0] RST_OFFSET = 16'h0000;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [7:0] addr;
    logic [23:0] wdata;
    logic wr;
    logic rd;
  } apedp_bus_type;

  typedef struct packed {
    logic signed [23:0] current;
    logic signed [23:0] voltage;
  } apedp_sample_type;

  typedef struct packed {
    logic [23:0] data;
    logic valid;
  } apedp_wave_type;

  typedef struct packed {
    logic [7:0] wave_src;
    logic [7:0] nl_mode;
    logic [7:0] acc_mode;
    logic [7:0] en_low;
    logic [7:0] en_high;
    logic [7:0] stat_low;
    logic [11:0] gain;
    logic [15:0] offset;
    logic [7:0] divider;
    logic signed [48:0] acc;
    logic signed [31:0] lpf;
    logic signed [23:0] power;
    logic prev_neg;
    logic [2:0] step_cnt;
    logic [13:0] wave_cnt;
    logic [23:0] rdata;
    logic irq;
    logic [23:0] wave_data;
    logic wave_valid;
  } apedp_state_type;

endpackage

// File: tb/apedp_top_tb.sv
// self-checking bench for the active power and energy datapath
// assumes apedp_pkg and apedp_top are compiled first; the bench drives every port
`timescale 1ns/1ps
module apedp_top_tb;
  import apedp_pkg::*;
  // ==========================================================
  // signals, counters and expectation queues
  logic clk = 1'b0;
  logic nrst = 1'b0;
  apedp_bus_type bus = '0;
  apedp_sample_type samples = '0;
  logic [23:0] reg_rdata;
  logic irq_pending;
  apedp_wave_type wave;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int last_valid = 0;
  logic rd_d = 1'b0;
  logic [31:0] seed = 32'd28129;
  logic [47:0] rd_q[$];
  logic [23:0] wave_q[$];
  int per_q[$];
  localparam logic [7:0] REGS[9] = '{8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'hD9, 8'hDB, 8'hDC};
  localparam logic [15:0] OFFS[6] = '{16'h4000, 16'h4000, 16'h4000, 16'h4000, 16'h0100, 16'hFF00};
  localparam logic [11:0] GAINS[6] = '{12'h000, 12'h800, 12'h400, 12'h7FF, 12'h000, 12'h000};
  localparam logic [23:0] PWRS[6] = '{24'h40, 24'h20, 24'h50, 24'h5F, 24'h1, 24'hFFFFFF};

  // short wave period keeps the rate checks brief
  apedp_top #(.WAVE_BASE_CYCLES(8)) dut (.clk(clk), .nrst(nrst), .bus(bus), .samples(samples),
    .reg_rdata(reg_rdata), .irq_pending(irq_pending), .wave(wave));

  always #10 clk = ~clk;

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask

  // strobes drop for one cycle so no signal is set twice in a time step
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [23:0] e, input logic [23:0] m);
    rd_q.push_back({m, e & m});
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic drain();
    for (int k = 0; k < 200 && (wave_q.size() + per_q.size()) > 0; k++) @(posedge clk);
    check("wave notes left", 24'h0, 24'(wave_q.size() + per_q.size()));
  endtask

  task automatic sgn(input logic dir, input logic [15:0] from, input logic [15:0] to, input logic e);
    wr(ADDR_ACC_MODE, 24'(dir) << ACC_SIGN_DIR_BIT);
    wr(ADDR_OFFSET, {8'h00, from});
    ticks(20);
    wr(ADDR_IRQ_STAT_LOW, 24'h00000F);
    wr(ADDR_OFFSET, {8'h00, to});
    ticks(20);
    rd(ADDR_IRQ_STAT_LOW, 24'(e) << STAT_SIGN_BIT, 24'(1) << STAT_SIGN_BIT);
  endtask

  // ==========================================================
  // read strobe delayed to the edge that launches the read data
  always @(posedge clk) begin
    rd_d <= bus.rd;
  end

  // watcher: each result takes the oldest note; also the hang limit
  // looks on the falling edge so registered outputs are settled, not racing their launch
  always @(negedge clk) begin
    cycles <= cycles + 1;
    if (rd_d && rd_q.size() > 0) begin
      check("register read", rd_q[0][23:0], reg_rdata & rd_q[0][47:24]);
      void'(rd_q.pop_front());
    end
    if (wave.valid) begin
      last_valid <= cycles;
      if (per_q.size() > 0) check("wave period", 24'(per_q.pop_front()), 24'(cycles - last_valid));
      if (wave_q.size() > 0) check("wave data", wave_q.pop_front(), wave.data);
    end
    if (cycles == 60000) begin
      n_errors++;
      end_of_test();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    ticks(10);
    nrst <= 1'b1;
    @(posedge clk);
    // every register except the two energy addresses reads zero after reset
    foreach (REGS[i]) rd(REGS[i], 24'h0, 24'hFFFFFF);
    // random readback, bits above the width read zero; unmapped reads zero
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(ADDR_GAIN, seed[23:0]);
      wr(ADDR_OFFSET, seed[31:8]);
      wr(ADDR_DIVIDER, seed[27:4]);
      rd(ADDR_GAIN, {12'h000, seed[11:0]}, 24'hFFFFFF);
      rd(ADDR_OFFSET, {8'h00, seed[23:8]}, 24'hFFFFFF);
      rd(ADDR_DIVIDER, {16'h0000, seed[11:4]}, 24'hFFFFFF);
      rd(8'h20 + {2'b00, seed[29:24]}, 24'h0, 24'hFFFFFF);
    end
    wr(ADDR_DIVIDER, 24'h0);
    $display("test registers done");
    // gain and offset seen on the waveform port
    wr(ADDR_IRQ_EN_HIGH, 24'(1) << EN_HIGH_WAVE_BIT);
    wr(ADDR_WAVE_SRC, {21'h0, WAVE_SRC_ACTIVE});
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_OFFSET, {8'h00, OFFS[i]});
      wr(ADDR_GAIN, {12'h000, GAINS[i]});
      ticks(40);
      wave_q.push_back(PWRS[i]);
      drain();
    end
    // four waveform rates, slowest period last
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_WAVE_SRC, 24'(r) << WAVE_RATE_LSB);
      ticks((16 << r) + 4);
      per_q.push_back(8 << r);
      drain();
    end
    $display("test power and waveform done");
    // sign change flag in both directions
    sgn(1'b0, 16'h2000, 16'hE000, 1'b1);
    sgn(1'b0, 16'hE000, 16'h2000, 1'b0);
    sgn(1'b1, 16'h2000, 16'hE000, 1'b0);
    sgn(1'b1, 16'hE000, 16'h2000, 1'b1);
    wr(ADDR_IRQ_EN_LOW, 24'(1) << STAT_SIGN_BIT);
    ticks(3);
    check("irq", 24'h1, {23'h0, irq_pending});
    wr(ADDR_IRQ_EN_LOW, 24'h0);
    $display("test sign change done");
    // no-load at every threshold code with a one-count power
    wr(ADDR_OFFSET, 24'h000100);
    for (int t = 1; t < 4; t++) begin
      wr(ADDR_NL_MODE, 24'(t));
      wr(ADDR_IRQ_STAT_LOW, 24'h00000F);
      ticks(20);
      rd(ADDR_IRQ_STAT_LOW, 24'h2, 24'h2);
    end
    ticks(3);
    check("irq masked", 24'h0, {23'h0, irq_pending});
    wr(ADDR_IRQ_EN_LOW, 24'(1) << STAT_NOLOAD_BIT);
    ticks(3);
    check("irq", 24'h1, {23'h0, irq_pending});
    wr(ADDR_NL_MODE, 24'h0);
    ticks(20);
    rd(ADDR_IRQ_STAT_LOW, 24'h2, 24'h2);
    wr(ADDR_IRQ_STAT_LOW, 24'h000002);
    ticks(3);
    rd(ADDR_IRQ_STAT_LOW, 24'h0, 24'h2);
    check("irq cleared", 24'h0, {23'h0, irq_pending});
    wr(ADDR_IRQ_EN_LOW, 24'h0);
    $display("test no-load done");
    // energy with full-scale negative power in each mode
    wr(ADDR_OFFSET, 24'h0);
    wr(ADDR_ACC_MODE, 24'h0);
    samples <= '{current: 24'h7FFFFF, voltage: 24'h800001};
    ticks(10000);
    rd(ADDR_ENERGY, 24'h800000, 24'h800000);
    wr(ADDR_ACC_MODE, 24'(1) << ACC_POS_ONLY_BIT);
    rd(ADDR_ENERGY_RC, 24'h800000, 24'h800000);
    rd(ADDR_ENERGY, 24'h0, 24'hFFFFFF);
    ticks(5000);
    rd(ADDR_ENERGY, 24'h0, 24'hFFFFFF);
    wr(ADDR_ACC_MODE, (24'(1) << ACC_POS_ONLY_BIT) | (24'(1) << ACC_ABS_BIT));
    ticks(5000);
    rd(ADDR_ENERGY, 24'h0, 24'hFFFFFF);
    // magnitude mode: about a quarter count per step, halved by the divider
    wr(ADDR_ACC_MODE, 24'(1) << ACC_ABS_BIT);
    ticks(10000);
    rd(ADDR_ENERGY_RC, 24'h000100, 24'hFFFF00);
    wr(ADDR_DIVIDER, 24'h000002);
    ticks(10000);
    rd(ADDR_ENERGY, 24'h000080, 24'hFFFF80);
    $display("test energy done");
    end_of_test();
  end
endmodule
